//--- hw/dbtc_pkg.sv
// Package for the debug trigger control block: offsets, fields, reset values, types.
// Assumes a plain register port with one-cycle read latency on mclk_in.
//
// Function
// - Config readable always, writable only disarmed
// - Config bits 4 and 5 read zero
// - Qualify set: modes 0 to 4 trigger only on executed opcode
// - Qualify clear: trigger on any access
// - Start-mode bit: begin or end trace
// - Event-only modes always begin trace
// - Modes: A only, A or B, A then B
// - Modes: event B, A then event B
// - Full modes: A and B, A and not B
// - Modes: inside range, outside range
// - Modes 1001 to 1111 never trigger
// - Status register is read only
package dbtc_pkg;

  // Register offsets on the plain port
  localparam logic [3:0] DBTC_CFG_OFFSET  = 4'h0;
  localparam logic [3:0] DBTC_STAT_OFFSET = 4'h1;

  // Field positions of the trigger configuration
  localparam int DBTC_QUAL_BIT  = 7;
  localparam int DBTC_BEGIN_BIT = 6;
  localparam int DBTC_MODE_LSB  = 0;

  // Reset value and read mask of the trigger configuration
  localparam logic [7:0] DBTC_CFG_RESET = 8'h00;
  localparam logic [7:0] DBTC_CFG_MASK  = 8'hcf;

  // Status bit positions
  localparam int DBTC_ST_ARMED  = 7;
  localparam int DBTC_ST_AHIT   = 6;
  localparam int DBTC_ST_TRIG   = 5;
  localparam int DBTC_ST_STORE  = 4;

  // Opcode tracking latency in cycles (fetch to execute)
  localparam int DBTC_TRACK_DEPTH = 2;

  // Trigger mode encodings
  localparam logic [3:0] DBTC_M_A_ONLY   = 4'h0;
  localparam logic [3:0] DBTC_M_A_OR_B   = 4'h1;
  localparam logic [3:0] DBTC_M_A_THEN_B = 4'h2;
  localparam logic [3:0] DBTC_M_EV_B     = 4'h3;
  localparam logic [3:0] DBTC_M_A_EV_B   = 4'h4;
  localparam logic [3:0] DBTC_M_A_AND_B  = 4'h5;
  localparam logic [3:0] DBTC_M_A_NAND_B = 4'h6;
  localparam logic [3:0] DBTC_M_INSIDE   = 4'h7;
  localparam logic [3:0] DBTC_M_OUTSIDE  = 4'h8;

  // Trigger configuration layout
  typedef struct packed {
    logic       opcode_qualify;   // Tag on execution
    logic       begin_trace;      // Trigger starts storage
    logic [1:0] zero;             // Always zero
    logic [3:0] trigger_mode_field; // Mode select
  } dbtc_cfg_t;

  // Comparator results for one bus cycle
  typedef struct packed {
    logic match_a;                // Address equals A
    logic match_b;                // Address (or data) equals B
    logic addr_ge_a;              // Address at or above A
    logic addr_le_b;              // Address at or below B
  } dbtc_cmp_t;

  // Sequencer states
  typedef enum logic [1:0] {
    DBTC_IDLE,
    DBTC_WAIT_B,
    DBTC_DONE
  } dbtc_seq_t;

endpackage

//--- hw/dbtc_tag_track.sv
// Opcode tracking for one comparator match: delays a tagged fetch until it executes.
// Assumes exec_in pulses when the opcode fetched DBTC_TRACK_DEPTH cycles back executes
// and flush_in discards all fetches in flight.
`timescale 1ns/1ps
module dbtc_tag_track (
  input  wire logic mclk_in,     // Core clock
  input  wire logic rst_in,      // Async reset, high
  input  wire logic match_in,    // Raw match this cycle
  input  wire logic fetch_in,    // Access is an opcode fetch
  input  wire logic exec_in,     // Oldest fetch executes
  input  wire logic flush_in,    // Pipeline flush
  output logic      tagged_out   // Match of executed opcode
);

  // Tags in flight, one per pipeline slot
  logic [dbtc_pkg::DBTC_TRACK_DEPTH-1:0] pipe_reg;

  // Shift the tag along with the fetched opcode
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pipe_reg <= '0;
    end else if (flush_in) begin
      pipe_reg <= '0;
    end else begin
      pipe_reg <= {pipe_reg[dbtc_pkg::DBTC_TRACK_DEPTH-2:0], match_in & fetch_in};
    end
  end

  // Tag only reaches the trigger logic on execution
  assign tagged_out = pipe_reg[dbtc_pkg::DBTC_TRACK_DEPTH-1] & exec_in & ~flush_in;

endmodule

//--- hw/dbtc_trig_eval.sv
// Combinational trigger-mode decode from qualified comparator events.
// Assumes all inputs are settled within one core clock cycle.
`timescale 1ns/1ps
module dbtc_trig_eval (
  input  wire logic [3:0]       mode_in,   // Trigger mode field
  input  wire logic             ev_a_in,   // Qualified A event
  input  wire logic             ev_b_in,   // Qualified B event
  input  wire logic             ev_full_in,// Qualified full-mode address A event
  input  wire dbtc_pkg::dbtc_cmp_t cmp_in, // Raw comparator results
  input  wire logic             a_seen_in, // A already seen this run
  output logic                  hit_out,   // Trigger this cycle
  output logic                  event_out, // Event-only store strobe
  output logic                  evonly_out // Mode is event-only
);

  // Decode the selected mode
  always_comb begin
    hit_out    = 1'b0;
    event_out  = 1'b0;
    evonly_out = 1'b0;
    case (mode_in)
      dbtc_pkg::DBTC_M_A_ONLY:   hit_out = ev_a_in;
      dbtc_pkg::DBTC_M_A_OR_B:   hit_out = ev_a_in | ev_b_in;
      dbtc_pkg::DBTC_M_A_THEN_B: hit_out = a_seen_in & ev_b_in;
      dbtc_pkg::DBTC_M_EV_B: begin
        evonly_out = 1'b1;
        event_out  = ev_b_in;
        hit_out    = ev_b_in;
      end
      dbtc_pkg::DBTC_M_A_EV_B: begin
        evonly_out = 1'b1;
        event_out  = a_seen_in & ev_b_in;
        hit_out    = a_seen_in & ev_b_in;
      end
      dbtc_pkg::DBTC_M_A_AND_B:  hit_out = ev_full_in & cmp_in.match_b;
      dbtc_pkg::DBTC_M_A_NAND_B: hit_out = ev_full_in & ~cmp_in.match_b;
      dbtc_pkg::DBTC_M_INSIDE:   hit_out = cmp_in.addr_ge_a & cmp_in.addr_le_b;
      dbtc_pkg::DBTC_M_OUTSIDE:  hit_out = ~cmp_in.addr_ge_a | ~cmp_in.addr_le_b;
      default:                   hit_out = 1'b0;
    endcase
  end

endmodule

//--- hw/dbtc_top.sv
// Debug trigger control: configuration register, qualification, sequencing, FIFO steering.
// Assumes comparators supply per-cycle results, arm control supplies arm_in,
// and the trace FIFO follows store_out one cycle after the bus access.
`timescale 1ns/1ps
module dbtc_top (
  input  wire logic                mclk_in,    // Core clock, 125 MHz
  input  wire logic                rst_in,     // Async reset, high
  input  wire logic [3:0]          addr_in,    // Register address
  input  wire logic [7:0]          wdata_in,   // Register write data
  input  wire logic                wr_in,      // Write strobe
  input  wire logic                rd_in,      // Read strobe
  output logic      [7:0]          rdata_out,  // Read data, next cycle
  input  wire logic                arm_in,     // Debugger armed
  input  wire logic                access_in,  // Bus access this cycle
  input  wire logic                fetch_in,   // Access is opcode fetch
  input  wire logic                exec_in,    // Oldest fetch executes
  input  wire logic                flush_in,   // Pipeline flush
  input  wire dbtc_pkg::dbtc_cmp_t cmp_in,     // Comparator results
  output logic                     trig_out,   // Trigger event pulse
  output logic                     store_out,  // Store this access in FIFO
  output logic                     begin_out,  // Effective begin trace
  output logic [7:0]               cfg_out     // Config to other logic
);

  // Trigger path in short
  // Comparators report matches for every bus cycle
  // Force qualify takes the raw match of any access
  // Tag qualify follows a fetch until it executes
  // Mode decode turns qualified events into a hit
  // Sequencer keeps an A event for the two-step modes
  // First hit of a run becomes the trigger pulse, every hit in event-only modes
  // Event-only modes store every qualifying B event
  // Other modes steer stores through a capture window
  //
  // Capture window per trace type
  // End trace: opens on arming, closes at the trigger
  // Begin trace: opens at the trigger, stays until disarm
  // Event-only: window unused, each event stores
  //
  // Run boundaries
  // A run starts when the arm input rises
  // Disarm clears the sequencer, window and trigger flag
  // A hit in the arming cycle already counts
  //
  // Status view
  // Bit 7 armed, bit 6 sequencer out of idle (A seen or done)
  // Bit 5 trigger seen, bit 4 window open
  //
  // Limits that users should know
  // Writes while armed are dropped without a report
  // Writes to status or unmapped offsets do nothing
  // Range modes test the flags on every cycle
  // Full modes use the raw address A match
  // A flush drops tagged matches still in flight
  // Modes 9 to 15 never raise the trigger
  // Store lags its access by one clock
  // Read data stands for one clock after the strobe
  // Config bits 5 and 4 never hold a one
  //
  // Configuration register and status flags
  dbtc_pkg::dbtc_cfg_t cfg_reg;       // Trigger configuration
  dbtc_pkg::dbtc_seq_t seq_reg;       // Trigger sequencer
  dbtc_pkg::dbtc_seq_t seq_next;      // Next sequencer state
  logic                trig_reg;      // Trigger pulse register
  logic                store_reg;     // Store strobe register
  logic                capture_reg;   // Capture window open
  logic                capture_next;  // Next capture window
  logic                trig_seen_reg; // Sticky trigger seen
  logic [7:0]          rdata_reg;     // Read data register
  logic                arm_d_reg;     // Arm delayed for edge

  // Qualified events and decode results
  logic tag_a;        // Executed-opcode A match
  logic tag_b;        // Executed-opcode B match
  logic ev_a;         // Selected A event
  logic ev_b;         // Selected B event
  logic ev_full;      // Full-mode A address event
  logic hit;          // Trigger this cycle
  logic ev_store;     // Event-only store strobe
  logic evonly;       // Event-only mode active
  logic begin_eff;    // Effective begin trace
  logic arm_rise;     // Arm rising edge
  logic [7:0] status; // Status view

  // Both trackers share fetch, execute and flush
  // Each keeps its own tag bits
  // Opcode tracking for comparator A
  dbtc_tag_track u_track_a (
    .mclk_in    (mclk_in),
    .rst_in     (rst_in),
    .match_in   (cmp_in.match_a),
    .fetch_in   (fetch_in),
    .exec_in    (exec_in),
    .flush_in   (flush_in),
    .tagged_out (tag_a)
  );

  // Opcode tracking for comparator B
  dbtc_tag_track u_track_b (
    .mclk_in    (mclk_in),
    .rst_in     (rst_in),
    .match_in   (cmp_in.match_b),
    .fetch_in   (fetch_in),
    .exec_in    (exec_in),
    .flush_in   (flush_in),
    .tagged_out (tag_b)
  );

  // Pick tagged or forced events
  // Tagged events arrive two cycles after the fetch
  // Forced events need a real access this cycle
  always_comb begin
    if (cfg_reg.opcode_qualify) begin
      ev_a = tag_a;
      ev_b = tag_b;
    end else begin
      ev_a = access_in & cmp_in.match_a;
      ev_b = access_in & cmp_in.match_b;
    end
  end

  // Full modes compare address and data of one access, range modes every cycle
  // Never tagged, so qualify has no effect here
  assign ev_full = access_in & cmp_in.match_a;

  // Mode decode
  // A seen means the sequencer waits for B
  dbtc_trig_eval u_eval (
    .mode_in    (cfg_reg.trigger_mode_field),
    .ev_a_in    (ev_a),
    .ev_b_in    (ev_b),
    .ev_full_in (ev_full),
    .cmp_in     (cmp_in),
    .a_seen_in  (seq_reg == dbtc_pkg::DBTC_WAIT_B),
    .hit_out    (hit),
    .event_out  (ev_store),
    .evonly_out (evonly)
  );

  assign begin_eff = evonly | cfg_reg.begin_trace;
  // Arm rise starts a new debug run
  assign arm_rise  = arm_in & ~arm_d_reg;

  // Arm edge tracking
  // Cleared by reset, so arming right after reset starts a run
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      arm_d_reg <= 1'b0;
    end else begin
      arm_d_reg <= arm_in;
    end
  end

  // Status and unmapped offsets ignore writes
  // Armed writes are dropped silently
  // write only while disarmed
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_reg <= dbtc_pkg::DBTC_CFG_RESET;
    end else if (wr_in && !arm_in && addr_in == dbtc_pkg::DBTC_CFG_OFFSET) begin
      cfg_reg <= wdata_in & dbtc_pkg::DBTC_CFG_MASK;
    end
  end

  // Sequencer next state
  // Only the two-step modes leave idle
  // Disarm always returns to idle
  always_comb begin
    seq_next = seq_reg;
    case (seq_reg)
      // Waiting for A when the mode needs one
      dbtc_pkg::DBTC_IDLE: begin
        if (arm_in && ev_a && (cfg_reg.trigger_mode_field == dbtc_pkg::DBTC_M_A_THEN_B ||
            cfg_reg.trigger_mode_field == dbtc_pkg::DBTC_M_A_EV_B)) begin
          seq_next = dbtc_pkg::DBTC_WAIT_B;
        end
      end
      // A seen, waiting for B
      dbtc_pkg::DBTC_WAIT_B: begin
        if (!arm_in) begin
          seq_next = dbtc_pkg::DBTC_IDLE;
        end else if (hit && !evonly) begin
          seq_next = dbtc_pkg::DBTC_DONE;
        end
      end
      // Sequence finished for this run
      dbtc_pkg::DBTC_DONE: begin
        if (!arm_in) begin
          seq_next = dbtc_pkg::DBTC_IDLE;
        end
      end
      default: seq_next = dbtc_pkg::DBTC_IDLE;
    endcase
  end

  // Sequencer state register
  // Holds one step per debug run
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      seq_reg <= dbtc_pkg::DBTC_IDLE;
    end else begin
      seq_reg <= seq_next;
    end
  end

  // Trigger takes priority over the arming edge
  // capture window per trace type
  always_comb begin
    capture_next = capture_reg;
    if (!arm_in) begin
      // Disarmed, nothing is captured
      capture_next = 1'b0;
    end else if (hit && !trig_seen_reg && !evonly) begin
      // Trigger opens a begin trace, ends an end trace
      capture_next = begin_eff;
    end else if (arm_rise) begin
      // End trace fills from arming, begin trace waits
      capture_next = ~begin_eff;
    end
  end

  // Capture window register
  // Drives the store strobe in the modes with a trigger
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      capture_reg <= 1'b0;
    end else begin
      capture_reg <= capture_next;
    end
  end

  // Sticky trigger seen in this run
  // Cleared while disarmed, so the arming cycle can trigger
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      trig_seen_reg <= 1'b0;
    end else if (!arm_in) begin
      // No run, nothing seen
      trig_seen_reg <= 1'b0;
    end else if (hit) begin
      // First hit of the run
      trig_seen_reg <= 1'b1;
    end
  end

  // Trigger pulse and store strobe
  // Trigger fires once per run outside event-only modes
  // Both pulses last one clock
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      trig_reg  <= 1'b0;
      store_reg <= 1'b0;
    end else begin
      trig_reg <= arm_in & hit & (evonly | ~trig_seen_reg);
      if (evonly) begin
        store_reg <= arm_in & ev_store;
      end else begin
        // Store accesses inside the window
        store_reg <= arm_in & access_in & (capture_reg | (hit & begin_eff & ~trig_seen_reg));
      end
    end
  end

  // Status view of the block's own state
  // Bits 3 to 0 read as zero
  always_comb begin
    status = 8'h00;
    status[dbtc_pkg::DBTC_ST_ARMED] = arm_in;
    status[dbtc_pkg::DBTC_ST_AHIT]  = (seq_reg != dbtc_pkg::DBTC_IDLE);
    status[dbtc_pkg::DBTC_ST_TRIG]  = trig_seen_reg;
    status[dbtc_pkg::DBTC_ST_STORE] = capture_reg;
  end

  // Read data one cycle after the strobe
  // Zero outside the answer cycle
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        dbtc_pkg::DBTC_CFG_OFFSET:  rdata_reg <= cfg_reg & dbtc_pkg::DBTC_CFG_MASK;
        dbtc_pkg::DBTC_STAT_OFFSET: rdata_reg <= status;
        default:                    rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // Outputs
  // Config leaves with bits 5 and 4 already zero
  assign rdata_out = rdata_reg;
  assign trig_out  = trig_reg;
  assign store_out = store_reg;
  assign begin_out = begin_eff;
  assign cfg_out   = cfg_reg;

endmodule

//--- test/dbtc_asserts.sv
// Checker for the debug trigger control, bound to the top module.
// Assumes one clock domain and the async active-high reset.
`timescale 1ns/1ps
module dbtc_asserts (
  input wire logic                mclk_in,   // Clock
  input wire logic                rst_in,    // Reset
  input wire logic [3:0]          addr_in,   // Address
  input wire logic [7:0]          wdata_in,  // Write data
  input wire logic                wr_in,     // Write
  input wire logic                rd_in,     // Read
  input wire logic [7:0]          rdata_out, // Read data
  input wire logic                arm_in,    // Armed
  input wire logic                access_in, // Access
  input wire logic                exec_in,   // Execute
  input wire dbtc_pkg::dbtc_cmp_t cmp_in,    // Compares
  input wire logic                trig_out,  // Trigger
  input wire logic                store_out, // Store
  input wire logic                begin_out, // Begin
  input wire logic [7:0]          cfg_out    // Config
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  logic fired_reg; // Trigger already seen this run

  // Remember the first trigger until disarm
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fired_reg <= 1'b0;
    end else begin
      fired_reg <= arm_in && (fired_reg || trig_out);
    end
  end

  a_mask_bits_zero: assert property (cfg_out[5:4] == 2'b00)
    else $error("config bits 5:4 not zero");
  a_armed_write_lock: assert property (arm_in && wr_in && addr_in == 4'h0 |=>
    $stable(cfg_out)) else $error("config changed while armed");
  a_open_write_lands: assert property (!arm_in && wr_in && addr_in == 4'h0 |=>
    cfg_out == ($past(wdata_in) & 8'hcf)) else $error("config write lost");
  a_cfg_read_back: assert property (rd_in && addr_in == 4'h0 |=>
    rdata_out == $past(cfg_out)) else $error("config read wrong");
  a_idle_read_zero: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data without read");
  a_disarm_quiet: assert property (!arm_in |=> !trig_out && !store_out)
    else $error("activity while disarmed");
  a_dead_modes: assert property (cfg_out[3:0] > 4'h8 |=> !trig_out)
    else $error("trigger in dead mode");
  a_evonly_begin: assert property (cfg_out[3:0] inside {4'h3, 4'h4} |-> begin_out)
    else $error("event mode not begin trace");
  a_begin_follows: assert property (!(cfg_out[3:0] inside {4'h3, 4'h4}) |->
    begin_out == cfg_out[6]) else $error("begin select wrong");
  a_tag_waits_exec: assert property (arm_in && cfg_out[7] && cfg_out[3:0] < 4'h5
    && !exec_in |=> !trig_out) else $error("tagged trigger without execution");
  a_force_fires: assert property (arm_in && cfg_out[7:0] inside {8'h00, 8'h40}
    && access_in && cmp_in.match_a && !fired_reg && !trig_out |=> trig_out)
    else $error("forced trigger missing");
  a_end_trace_fills: assert property (arm_in && $past(arm_in) && !begin_out && !fired_reg
    && !trig_out && access_in |=> store_out) else $error("end trace access not stored");
  a_end_trace_stops: assert property (arm_in && !begin_out && fired_reg |=> !store_out)
    else $error("end trace stored after trigger");
  a_event_store: assert property (arm_in && !cfg_out[7] && cfg_out[3:0] == 4'h3
    && access_in && cmp_in.match_b |=> store_out) else $error("event store missing");
endmodule

//--- test/dbtc_opcode_model.sv
// Opcode tracking model: an opcode fetched now executes two cycles later.
// Assumes fetch_in changes after a clock edge; kill_in drops executions.
`timescale 1ns/1ps
module dbtc_opcode_model (
  input  wire logic mclk_in,  // Core clock
  input  wire logic rst_in,   // Async reset, high
  input  wire logic fetch_in, // Opcode fetch this cycle
  input  wire logic kill_in,  // Branch away, nothing executes
  output logic      exec_out  // Oldest fetch executes
);
  logic [1:0] pipe_reg; // Fetches in flight

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pipe_reg <= 2'b00;
    end else begin
      pipe_reg <= {pipe_reg[0], fetch_in};
    end
  end

  // Killed fetches never execute
  assign exec_out = pipe_reg[1] && !kill_in;
endmodule

//--- test/testbench.sv
// Bench for the debug trigger control: modes, qualify, write lock, reads.
// Assumes the checker and the opcode model are compiled before it.
`timescale 1ns/1ps
module testbench;
  logic                mclk_in = 1'b0;   // Clock
  logic                rst_in = 1'b1;    // Reset
  logic [3:0]          addr_in = 4'h0;   // Address
  logic [7:0]          wdata_in = 8'h00; // Write data
  logic                wr_in = 1'b0;     // Write
  logic                rd_in = 1'b0;     // Read
  logic [7:0]          rdata_out;        // Read data
  logic                arm_in = 1'b0;    // Armed
  logic                access_in = 1'b0; // Access
  logic                fetch_in = 1'b0;  // Fetch
  logic                exec_in;          // Execute
  logic                flush_in = 1'b0;  // Flush
  logic                kill_in = 1'b0;   // Drop executes
  dbtc_pkg::dbtc_cmp_t cmp_in = '0;      // Compares
  logic                trig_out;         // Trigger
  logic                store_out;        // Store
  logic                begin_out;        // Begin
  logic [7:0]          cfg_out;          // Config
  logic [15:0]         expq[$];          // Mask and value
  logic                rd_seen = 1'b0;   // Read last cycle
  int                  mismatches = 0;   // Errors
  int                  total_checks = 0; // Checks
  int                  cyc = 0;          // Cycle count
  logic [15:0]         pat[2] = '{16'h01df, 16'h01ab}; // Modes that fire
  logic [4:0]          pc[2][2] = '{'{5'h1b, 5'h17}, '{5'h15, 5'h1f}}; // Stimulus

  // Clock, 8 ns period
  always #4 mclk_in = ~mclk_in;

  dbtc_top dbtc_top_inst (.mclk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .arm_in, .access_in, .fetch_in, .exec_in, .flush_in, .cmp_in,
    .trig_out, .store_out, .begin_out, .cfg_out);
  dbtc_opcode_model dbtc_opcode_model_inst (.mclk_in, .rst_in, .fetch_in, .kill_in,
    .exec_out(exec_in));

  // Count and report one comparison
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic tally_and_finish(int extra);
    mismatches += extra;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One cycle of bus and comparator stimulus
  task automatic drv(logic w, logic r, logic [3:0] a, logic [7:0] d,
                     logic [15:0] e, logic [4:0] x);
    wr_in <= w;
    rd_in <= r;
    addr_in <= a;
    wdata_in <= d;
    access_in <= x[4];
    fetch_in <= x[4];
    cmp_in <= x[3:0];
    if (r) expq.push_back(e);
    @(posedge mclk_in);
  endtask

  // One debug run: configure, arm, stimulate, read back
  task automatic run(logic [3:0] m, int p, logic q, logic k);
    logic [7:0] c;
    logic       t;
    c = {q, 1'($urandom), 2'($urandom), m};
    t = pat[p][m] && !(q && k && m < 4'h5);
    arm_in <= 1'b0;
    kill_in <= k;
    drv(1, 0, 4'h0, c, 0, 0);
    drv(0, 1, 4'h0, 0, {8'hff, c & dbtc_pkg::DBTC_CFG_MASK}, 0);
    drv(0, 1, 4'h9, 0, 16'hff00, 0);
    arm_in <= 1'b1;
    drv(1, 0, 4'h0, 8'($urandom), 0, 0);
    drv(1, 0, 4'h1, 8'hff, 0, pc[p][0]);
    drv(0, 0, 4'h0, 0, 0, pc[p][1]);
    flush_in <= k;
    drv(0, 0, 4'h0, 0, 0, 0);
    flush_in <= 1'b0;
    repeat (4) drv(0, 0, 4'h0, 0, 0, 0);
    drv(0, 1, 4'h0, 0, {8'hff, c & dbtc_pkg::DBTC_CFG_MASK}, 0);
    drv(0, 1, 4'h1, 0, {8'ha0, 2'b10, t, 5'h00}, 0);
    drv(0, 0, 4'h0, 0, 0, 0);
  endtask

  // Compare each read with the oldest note
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    rd_seen <= rd_in;
    if (cyc == 20000) tally_and_finish(1);
    if (rd_seen && expq.size() == 0) tally_and_finish(1);
    if (rd_seen && expq.size() > 0) begin
      chk(rdata_out & expq[0][15:8], expq[0][7:0]);
      void'(expq.pop_front());
    end
  end

  // Main sequence
  initial begin
    void'($urandom(87794));
    repeat (8) @(posedge mclk_in);
    rst_in <= 1'b0;
    drv(0, 1, 4'h0, 0, {8'hff, dbtc_pkg::DBTC_CFG_RESET}, 0);
    for (int p = 0; p < 2; p++) begin
      for (int v = 0; v < 48; v++) begin
        run(v[3:0], p, v[4] | v[5], v[5]);
      end
      $display("pattern %0d done", p);
    end
    rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    drv(0, 1, 4'h0, 0, {8'hff, dbtc_pkg::DBTC_CFG_RESET}, 0);
    repeat (2) drv(0, 0, 4'h0, 0, 0, 0);
    $display("reset test done");
    tally_and_finish(expq.size());
  end
endmodule

bind dbtc_top dbtc_asserts dbtc_asserts_inst (.mclk_in, .rst_in, .addr_in, .wdata_in,
  .wr_in, .rd_in, .rdata_out, .arm_in, .access_in, .exec_in, .cmp_in, .trig_out,
  .store_out, .begin_out, .cfg_out);
